// ---- svd_cfg.svh ----
// opcode values, register field codes and widths for the opcode decoder
`ifndef SVD_CFG_SVH
`define SVD_CFG_SVH
`define SVD_OPW 8
`define SVD_RFW 4
`define SVD_OP_LEA_BASE 8'h52
`define SVD_OP_LEA_INDEX 8'h56
`define SVD_OP_CBR_AR_GT 8'h85
`define SVD_OP_CBR_IX_LE 8'h86
`define SVD_OP_CBR_IX_GT 8'h87
`define SVD_OP_MCALL_GO 8'h90
`define SVD_OP_CCBR 8'h91
`define SVD_OP_PUSH 8'h93
`define SVD_OP_MCALL_WAIT 8'h94
`define SVD_OP_RCBR 8'h95
`define SVD_OP_PULL 8'h97
`define SVD_OP_BLINK_PC 8'h98
`define SVD_OP_BLINK_IX 8'h99
`define SVD_OP_XCBR 8'h9C
`define SVD_OP_AEBR 8'h9D
`define SVD_OP_VSTART 8'hB0
`define SVD_RF_VSTART_GO 4'h1
`define SVD_RF_VSTART_LOAD 4'h0
`define SVD_RF_UNCOND 4'h7
`define SVD_RF_NOP 4'h0
`define SVD_NOP_HI 4'h0
`endif

// ---- svd_pkg.sv ----
// types shared by the opcode decoder modules
package svd_pkg;
    typedef enum logic [4:0] {
        SVD_CL_ILLEGAL = 5'h00,
        SVD_CL_NOP = 5'h01,
        SVD_CL_CCBR = 5'h02,
        SVD_CL_RCBR = 5'h03,
        SVD_CL_AEBR = 5'h04,
        SVD_CL_XCBR = 5'h05,
        SVD_CL_VSTART = 5'h06,
        SVD_CL_MCALL = 5'h07,
        SVD_CL_STACK = 5'h08,
        SVD_CL_BLINK = 5'h09,
        SVD_CL_LEA = 5'h0A,
        SVD_CL_CONV = 5'h0B,
        SVD_CL_CMPBR = 5'h0C,
        SVD_CL_V_ADDSUB = 5'h0D,
        SVD_CL_V_MULDIV = 5'h0E,
        SVD_CL_V_SEARCH = 5'h0F,
        SVD_CL_V_LOGIC = 5'h10,
        SVD_CL_V_SHIFT = 5'h11,
        SVD_CL_V_SELREP = 5'h12,
        SVD_CL_V_MERGE = 5'h13,
        SVD_CL_V_ORDER = 5'h14,
        SVD_CL_V_PEAK = 5'h15,
        SVD_CL_V_CMP = 5'h16,
        SVD_CL_V_CONV = 5'h17
    } svd_class_t;
    typedef enum logic [1:0] {
        SVD_LEN_FX_SINGLE = 2'h0,
        SVD_LEN_FX_HALF = 2'h1,
        SVD_LEN_FL_SINGLE = 2'h2,
        SVD_LEN_FL_DOUBLE = 2'h3
    } svd_len_t;
endpackage : svd_pkg

// ---- svd_dec_if.sv ----
// decoded operation carried between decoder stages
`timescale 1ns/10ps
interface svd_dec_if;
    logic valid;
    svd_pkg::svd_class_t op_class;
    logic [3:0] sub_op;
    svd_pkg::svd_len_t len;
    logic [3:0] reg_sel;
    logic [3:0] cond;
    modport src (output valid, output op_class, output sub_op, output len,
        output reg_sel, output cond);
    modport dst (input valid, input op_class, input sub_op, input len,
        input reg_sel, input cond);
endinterface : svd_dec_if

// ---- svd_scalar_map.sv ----
// combinational scalar opcode map for the special scalar operations
`timescale 1ns/10ps
`include "svd_cfg.svh"
module svd_scalar_map (
    // opcode and register field
    input wire logic [7:0] op_in,
    input wire logic [3:0] rf_in,
    // decoded result
    output logic hit_out,
    output svd_pkg::svd_class_t class_out,
    output logic [3:0] sub_out,
    output logic [3:0] cond_out
);
    // opcode lookup
    always_comb begin
        hit_out = 1'b1;
        class_out = svd_pkg::SVD_CL_ILLEGAL;
        sub_out = 4'h0;
        cond_out = rf_in;
        if (op_in == `SVD_OP_CCBR) begin
            class_out = (rf_in == `SVD_RF_NOP) ? svd_pkg::SVD_CL_NOP : svd_pkg::SVD_CL_CCBR;
        end else if (op_in == `SVD_OP_RCBR) begin
            class_out = svd_pkg::SVD_CL_RCBR;
        end else if (op_in == `SVD_OP_AEBR) begin
            class_out = svd_pkg::SVD_CL_AEBR;
        end else if (op_in == `SVD_OP_XCBR) begin
            class_out = svd_pkg::SVD_CL_XCBR;
        end else if (op_in == `SVD_OP_MCALL_GO || op_in == `SVD_OP_MCALL_WAIT) begin
            class_out = svd_pkg::SVD_CL_MCALL;
            sub_out = {3'h0, op_in == `SVD_OP_MCALL_WAIT};
        end else if (op_in == `SVD_OP_PUSH || op_in == `SVD_OP_PULL) begin
            class_out = svd_pkg::SVD_CL_STACK;
            sub_out = {3'h0, op_in == `SVD_OP_PULL};
        end else if (op_in == `SVD_OP_BLINK_PC || op_in == `SVD_OP_BLINK_IX) begin
            class_out = svd_pkg::SVD_CL_BLINK;
            sub_out = {3'h0, op_in == `SVD_OP_BLINK_IX};
        end else if (op_in == `SVD_OP_LEA_BASE || op_in == `SVD_OP_LEA_INDEX) begin
            class_out = svd_pkg::SVD_CL_LEA;
            sub_out = {3'h0, op_in == `SVD_OP_LEA_INDEX};
        end else if (op_in == `SVD_OP_CBR_AR_GT || op_in == `SVD_OP_CBR_IX_LE
                || op_in == `SVD_OP_CBR_IX_GT) begin
            class_out = svd_pkg::SVD_CL_CMPBR;
            sub_out = {2'h0, op_in[1:0]};
        end else if (op_in == `SVD_OP_VSTART) begin
            class_out = svd_pkg::SVD_CL_VSTART;
            sub_out = {3'h0, rf_in == `SVD_RF_VSTART_LOAD};
        end else if (op_in[7:4] == 4'hA && (op_in[3:0] <= 4'h2
                || (op_in[3:0] >= 4'h8 && op_in[3:0] <= 4'hD))) begin
            class_out = svd_pkg::SVD_CL_CONV;
            sub_out = op_in[3:0];
        end else begin
            hit_out = 1'b0;
        end
    end
endmodule : svd_scalar_map

// ---- svd_vector_map.sv ----
// combinational vector opcode map
`timescale 1ns/10ps
`include "svd_cfg.svh"
module svd_vector_map (
    // opcode
    input wire logic [7:0] op_in,
    // decoded result
    svd_dec_if.src dec
);
    logic [3:0] lo;
    assign lo = op_in[3:0];
    assign dec.reg_sel = 4'h0;
    assign dec.cond = 4'h0;
    assign dec.len = svd_pkg::svd_len_t'(op_in[1:0]);
    // vector family lookup
    always_comb begin
        dec.valid = 1'b1;
        dec.op_class = svd_pkg::SVD_CL_ILLEGAL;
        dec.sub_op = {2'h0, op_in[3:2]};
        if (op_in[7:4] == 4'h4) begin
            dec.op_class = svd_pkg::SVD_CL_V_ADDSUB;
        end else if (op_in[7:4] == 4'h5) begin
            dec.op_class = svd_pkg::SVD_CL_V_SEARCH;
        end else if (op_in[7:4] == 4'h6 && lo >= 4'h4) begin
            dec.op_class = svd_pkg::SVD_CL_V_MULDIV;
        end else if (op_in[7:4] == 4'hA && (lo <= 4'h2 || (lo >= 4'h8 && lo <= 4'hD))) begin
            dec.op_class = svd_pkg::SVD_CL_V_CONV;
            dec.sub_op = lo;
        end else if (op_in[7:4] == 4'hB && (lo <= 4'h3 && lo != 4'h2
                || lo == 4'h8 || lo == 4'h9 || lo == 4'hB)) begin
            dec.op_class = svd_pkg::SVD_CL_V_SELREP;
            dec.sub_op = {3'h0, lo[3]};
        end else if (op_in[7:4] == 4'hC && lo != 4'h2 && lo != 4'h6
                && !(lo >= 4'h8 && lo <= 4'hB) && lo != 4'hE) begin
            dec.op_class = svd_pkg::SVD_CL_V_SHIFT;
        end else if (op_in[7:4] == 4'hD && lo != 4'hA) begin
            case (lo[3:2])
                2'h0: dec.op_class = svd_pkg::SVD_CL_V_CMP;
                2'h1: dec.op_class = svd_pkg::SVD_CL_V_ORDER;
                2'h2: dec.op_class = svd_pkg::SVD_CL_V_MERGE;
                default: dec.op_class = svd_pkg::SVD_CL_V_PEAK;
            endcase
        end else if (op_in[7:4] == 4'hE && lo != 4'hA && lo != 4'hB
                && lo != 4'hE && lo != 4'hF) begin
            dec.op_class = svd_pkg::SVD_CL_V_LOGIC;
        end else begin
            dec.valid = 1'b0;
        end
    end
endmodule : svd_vector_map

// ---- svd_decoder.sv ----
// top of the scalar and vector opcode decoder
`timescale 1ns/10ps
`include "svd_cfg.svh"
module svd_decoder #(
    parameter int OP_W = `SVD_OPW,
    parameter int RF_W = `SVD_RFW
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // instruction from fetch level
    input wire logic inst_valid_in,
    input wire logic [OP_W-1:0] op_in,
    input wire logic [RF_W-1:0] rf_in,
    input wire logic vector_mode_in,
    input wire logic remote_exec_in,
    // condition inputs for branch resolution
    input wire logic [3:0] arith_fault_in,
    input wire logic exec_cond_in,
    input wire logic logical_cmp_in,
    // decoded operation toward pipelines
    output logic issue_valid_out,
    output svd_pkg::svd_class_t class_out,
    output logic [3:0] sub_op_out,
    output svd_pkg::svd_len_t len_out,
    output logic [RF_W-1:0] reg_sel_out,
    output logic [3:0] cond_out,
    output logic logical_out,
    output logic fault_taken_out,
    output logic exec_taken_out,
    output logic illegal_out
);
    // parameter sanity, refused at elaboration
    if (OP_W != `SVD_OPW || RF_W != `SVD_RFW) begin : g_bad_width
        $error("svd_decoder: unsupported opcode or register field width");
    end

    logic s_hit;
    svd_pkg::svd_class_t s_class;
    logic [3:0] s_sub;
    logic [3:0] s_cond;
    svd_dec_if vdec ();

    // scalar special map
    svd_scalar_map u_smap (
        .op_in(op_in),
        .rf_in(rf_in),
        .hit_out(s_hit),
        .class_out(s_class),
        .sub_out(s_sub),
        .cond_out(s_cond)
    );

    // vector map
    svd_vector_map u_vmap (
        .op_in(op_in),
        .dec(vdec.src)
    );

    // checks the register field against a mask of present faults
    function automatic logic fault_hit(input logic [3:0] mask, input logic [3:0] faults);
        fault_hit = |(mask & faults);
    endfunction : fault_hit

    logic nop_word;
    logic legal_nxt;
    svd_pkg::svd_class_t class_nxt;
    logic [3:0] sub_nxt;
    logic [3:0] cond_nxt;
    svd_pkg::svd_len_t len_nxt;

    // remote words whose top opcode bits are zero act as no-operation
    assign nop_word = remote_exec_in && op_in[7:4] == `SVD_NOP_HI;

    // merge scalar and vector maps; row from bits 0-3, column from bits 4-7
    always_comb begin
        legal_nxt = 1'b0;
        class_nxt = svd_pkg::SVD_CL_ILLEGAL;
        sub_nxt = 4'h0;
        cond_nxt = 4'h0;
        len_nxt = svd_pkg::SVD_LEN_FX_SINGLE;
        if (nop_word) begin
            legal_nxt = 1'b1;
            class_nxt = svd_pkg::SVD_CL_NOP;
        end else if (vector_mode_in && vdec.valid) begin
            legal_nxt = 1'b1;
            class_nxt = vdec.op_class;
            sub_nxt = vdec.sub_op;
            cond_nxt = vdec.cond;
            len_nxt = vdec.len;
        end else if (s_hit) begin
            legal_nxt = 1'b1;
            class_nxt = s_class;
            sub_nxt = s_sub;
            cond_nxt = s_cond;
            len_nxt = svd_pkg::svd_len_t'(op_in[1:0]);
        end
    end

    // decoded word register, one instruction per cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            issue_valid_out <= 1'b0;
            illegal_out <= 1'b0;
            class_out <= svd_pkg::SVD_CL_ILLEGAL;
            sub_op_out <= 4'h0;
            len_out <= svd_pkg::SVD_LEN_FX_SINGLE;
            reg_sel_out <= '0;
            cond_out <= 4'h0;
            logical_out <= 1'b0;
        end else begin
            issue_valid_out <= inst_valid_in && legal_nxt;
            illegal_out <= inst_valid_in && !legal_nxt;
            class_out <= class_nxt;
            sub_op_out <= sub_nxt;
            len_out <= len_nxt;
            reg_sel_out <= rf_in;
            cond_out <= cond_nxt;
            logical_out <= logical_cmp_in;
        end
    end

    // branch resolution for exception and execute-condition branches
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fault_taken_out <= 1'b0;
            exec_taken_out <= 1'b0;
        end else begin
            fault_taken_out <= inst_valid_in && !nop_word && class_nxt == svd_pkg::SVD_CL_AEBR
                && fault_hit(rf_in, arith_fault_in);
            exec_taken_out <= inst_valid_in && !nop_word && class_nxt == svd_pkg::SVD_CL_XCBR
                && rf_in[0] && exec_cond_in;
        end
    end
endmodule : svd_decoder

// ---- svd_decoder_monitor.sv ----
// concurrent checks on the opcode decoder ports
`timescale 1ns/10ps
module svd_decoder_monitor #(
    parameter int OP_W = 8,
    parameter int RF_W = 4
) (
    // clock, reset and request
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic inst_valid_in,
    input wire logic [OP_W-1:0] op_in,
    input wire logic [RF_W-1:0] rf_in,
    input wire logic vector_mode_in,
    input wire logic remote_exec_in,
    input wire logic [3:0] arith_fault_in,
    input wire logic exec_cond_in,
    // decoded outputs
    input wire logic issue_valid_out,
    input wire svd_pkg::svd_class_t class_out,
    input wire logic [RF_W-1:0] reg_sel_out,
    input wire logic [3:0] cond_out,
    input wire logic fault_taken_out,
    input wire logic exec_taken_out,
    input wire logic illegal_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // exactly one answer per request, next edge
    a_one_answer: assert property (inst_valid_in |=> issue_valid_out != illegal_out)
        else $error("no single answer after request");
    a_reg_follow: assert property (inst_valid_in ##1 issue_valid_out |->
        reg_sel_out == $past(rf_in)) else $error("register select lost");
    a_nop_field: assert property (inst_valid_in && op_in == 8'h91 && rf_in == 4'h0
        && !vector_mode_in |=> class_out == svd_pkg::SVD_CL_NOP)
        else $error("field zero not decoded as no-operation");
    a_ccbr_cond: assert property (inst_valid_in && op_in == 8'h91 && rf_in inside {[1:7]}
        && !vector_mode_in |=> cond_out == $past(rf_in))
        else $error("compare condition wrong");
    a_fault_mask: assert property (inst_valid_in && op_in == 8'h9D && !vector_mode_in
        |=> fault_taken_out == |($past(rf_in) & $past(arith_fault_in)))
        else $error("fault branch wrong");
    a_exec_cond: assert property (inst_valid_in && op_in == 8'h9C && !vector_mode_in
        |=> exec_taken_out == ($past(rf_in[0]) && $past(exec_cond_in)))
        else $error("execute branch wrong");
    a_remote_nop: assert property (inst_valid_in && remote_exec_in && op_in[7:4] == 4'h0
        |=> issue_valid_out && class_out == svd_pkg::SVD_CL_NOP)
        else $error("remote word not no-operation");
    a_illegal_code: assert property (inst_valid_in && op_in == 8'h9E
        |=> illegal_out && !issue_valid_out) else $error("hole not illegal");
    // main scenarios seen
    c_fault: cover property (fault_taken_out);
    c_exec: cover property (exec_taken_out);
    c_illegal: cover property (illegal_out);
endmodule : svd_decoder_monitor

bind svd_decoder svd_decoder_monitor #(.OP_W(OP_W), .RF_W(RF_W)) i_mon (.*);

// ---- svd_fetch_model.sv ----
// fetch level model presenting instruction words to the decoder
`timescale 1ns/10ps
module svd_fetch_model (
    // clock and request from the bench
    input wire logic clk_in,
    input wire logic req_in,
    input wire logic [11:0] word_in,
    // opcode and register field toward the decoder
    output logic valid_out,
    output logic [11:0] word_out
);
    logic [11:0] last_r = 12'h0000;
    // idle lines show the inverse of the previous cycle's word, so they change every cycle
    always_ff @(posedge clk_in) begin
        last_r <= word_out;
    end
    assign valid_out = req_in;
    assign word_out = req_in ? word_in : ~last_r;
endmodule : svd_fetch_model

// ---- svd_decoder_tb.sv ----
// self-checking bench for the opcode decoder
`timescale 1ns/10ps
module svd_decoder_tb;
    logic clk_in, rst_in, req, vm, rem, lg, ec, inst_valid, iv, lo, ft, et, ill;
    logic [3:0] flt, sub, rs, cond;
    logic [11:0] word, word_w;
    logic [16:0] exp_row;
    svd_pkg::svd_class_t cls;
    svd_pkg::svd_len_t len;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    // op, field, vector mode, class, sub-operation
    logic [21:0] rows [28] = '{
        {8'h90, 4'h3, 1'b0, svd_pkg::SVD_CL_MCALL, 4'h0},
        {8'h94, 4'h3, 1'b0, svd_pkg::SVD_CL_MCALL, 4'h1},
        {8'h93, 4'h5, 1'b0, svd_pkg::SVD_CL_STACK, 4'h0},
        {8'h97, 4'hF, 1'b0, svd_pkg::SVD_CL_STACK, 4'h1},
        {8'h98, 4'h2, 1'b0, svd_pkg::SVD_CL_BLINK, 4'h0},
        {8'h99, 4'h2, 1'b0, svd_pkg::SVD_CL_BLINK, 4'h1},
        {8'h52, 4'h4, 1'b0, svd_pkg::SVD_CL_LEA, 4'h0},
        {8'h56, 4'h4, 1'b0, svd_pkg::SVD_CL_LEA, 4'h1},
        {8'h85, 4'h1, 1'b0, svd_pkg::SVD_CL_CMPBR, 4'h1},
        {8'h87, 4'h1, 1'b0, svd_pkg::SVD_CL_CMPBR, 4'h3},
        {8'hAB, 4'h0, 1'b0, svd_pkg::SVD_CL_CONV, 4'hB},
        {8'hB0, 4'h1, 1'b0, svd_pkg::SVD_CL_VSTART, 4'h0},
        {8'hB0, 4'h0, 1'b0, svd_pkg::SVD_CL_VSTART, 4'h1},
        {8'h4F, 4'h0, 1'b1, svd_pkg::SVD_CL_V_ADDSUB, 4'h3},
        {8'h6C, 4'h0, 1'b1, svd_pkg::SVD_CL_V_MULDIV, 4'h3},
        {8'h5F, 4'h0, 1'b1, svd_pkg::SVD_CL_V_SEARCH, 4'h3},
        {8'hE9, 4'h0, 1'b1, svd_pkg::SVD_CL_V_LOGIC, 4'h2},
        {8'hCF, 4'h0, 1'b1, svd_pkg::SVD_CL_V_SHIFT, 4'h3},
        {8'hBB, 4'h0, 1'b1, svd_pkg::SVD_CL_V_SELREP, 4'h1},
        {8'hD8, 4'h0, 1'b1, svd_pkg::SVD_CL_V_MERGE, 4'h2},
        {8'h86, 4'h1, 1'b0, svd_pkg::SVD_CL_CMPBR, 4'h2},
        {8'hAD, 4'h0, 1'b0, svd_pkg::SVD_CL_CONV, 4'hD},
        {8'hA9, 4'h0, 1'b1, svd_pkg::SVD_CL_V_CONV, 4'h9},
        {8'h64, 4'h0, 1'b1, svd_pkg::SVD_CL_V_MULDIV, 4'h1},
        {8'hD4, 4'h0, 1'b1, svd_pkg::SVD_CL_V_ORDER, 4'h1},
        {8'hDC, 4'h0, 1'b1, svd_pkg::SVD_CL_V_PEAK, 4'h3},
        {8'hD2, 4'h0, 1'b1, svd_pkg::SVD_CL_V_CMP, 4'h0},
        {8'hB3, 4'h0, 1'b1, svd_pkg::SVD_CL_V_SELREP, 4'h0}};
    // fetch level and decoder
    svd_fetch_model i_fetch (.clk_in(clk_in), .req_in(req), .word_in(word),
        .valid_out(inst_valid), .word_out(word_w));
    svd_decoder i_dut (.clk_in(clk_in), .rst_in(rst_in), .inst_valid_in(inst_valid),
        .op_in(word_w[11:4]), .rf_in(word_w[3:0]), .vector_mode_in(vm),
        .remote_exec_in(rem), .arith_fault_in(flt), .exec_cond_in(ec), .logical_cmp_in(lg),
        .issue_valid_out(iv), .class_out(cls), .sub_op_out(sub), .len_out(len),
        .reg_sel_out(rs), .cond_out(cond), .logical_out(lo), .fault_taken_out(ft),
        .exec_taken_out(et), .illegal_out(ill));
    // clock
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    task automatic chk(input string n, input logic [16:0] g, input logic [16:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // one instruction, x = vector mode, remote, logical, exec cond, faults
    task automatic run(input logic [7:0] o, input logic [3:0] r, input logic [7:0] x);
        @(posedge clk_in);
        req <= 1'b1;
        word <= {o, r};
        {vm, rem, lg, ec, flt} <= x;
        @(posedge clk_in);
        req <= 1'b0;
        #1;
    endtask : run
    task automatic stop_test();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    // hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        {rst_in, req, word, vm, rem, lg, ec, flt} = {1'b1, 21'h00_0000};
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        chk("reset", {iv, ill, cls}, 17'h0_0000);
        chk("reset flags", {ft, et, lo, cond, rs, len}, 17'h0_0000);
        // back-to-back rows, result of row i-1 seen after edge i
        for (int i = 0; i <= 28; i++) begin
            @(posedge clk_in);
            req <= (i < 28);
            if (i < 28) {word, vm} <= rows[i][21:9];
            #1;
            if (i > 0) begin
                exp_row = {2'b10, rows[i-1][8:0], rows[i-1][15:10]};
                chk("row", {iv, ill, cls, sub, len, rs}, exp_row);
            end
        end
        for (int r = 0; r < 8; r++) begin
            run(8'h91, r[3:0], 8'h00);
            exp_row = {8'h00, (r == 0) ? svd_pkg::SVD_CL_NOP : svd_pkg::SVD_CL_CCBR, r[3:0]};
            chk("ccbr", {cls, cond}, exp_row);
        end
        for (int r = 1; r < 7; r++) begin
            run(8'h91, r[3:0], 8'h20);
            chk("logic", {cls, cond, lo}, {svd_pkg::SVD_CL_CCBR, r[3:0], 1'b1});
            run(8'h95, r[3:0], {2'b00, r[0], 5'h00});
            chk("rcbr", {cls, cond, lo}, {svd_pkg::SVD_CL_RCBR, r[3:0], r[0]});
        end
        for (int r = 0; r < 16; r++) begin
            run(8'h9D, r[3:0], 8'h06);
            chk("fault", {cls, ft}, {svd_pkg::SVD_CL_AEBR, |(r[3:0] & 4'h6)});
        end
        for (int i = 0; i < 8; i++) begin
            run(8'h9C, {2'b00, i[1:0]}, {3'b000, i[2], 4'h0});
            chk("exec", {cls, et}, {svd_pkg::SVD_CL_XCBR, i[0] & i[2]});
        end
        run(8'h07, 4'h3, 8'h40);
        chk("remote", {iv, ill, cls}, {2'b10, svd_pkg::SVD_CL_NOP});
        run(8'h17, 4'h3, 8'h40);
        chk("remote hi", {iv, ill}, 17'h0_0001);
        run(8'h9E, 4'h0, 8'h00);
        chk("hole", {iv, ill}, 17'h0_0001);
        run(8'hEA, 4'h0, 8'h80);
        chk("vhole", {iv, ill}, 17'h0_0001);
        run(8'h60, 4'h0, 8'h80);
        chk("vhole 60", {iv, ill}, 17'h0_0001);
        // reset in mid-run drops the pending answer
        @(posedge clk_in);
        req <= 1'b1;
        word <= 12'h901;
        rst_in <= 1'b1;
        @(posedge clk_in);
        {req, rst_in} <= 2'b00;
        #1;
        chk("mid reset", {iv, ill, cls}, 17'h0_0000);
        run(8'h91, 4'h2, 8'h00);
        chk("after reset", {iv, cls, cond}, {8'h01, svd_pkg::SVD_CL_CCBR, 4'h2});
        stop_test();
    end
endmodule : svd_decoder_tb
